// >>> hw/rtc_pkg.sv
// Shared constants for the real-time counter and tick timer block.
package rtc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses on the register port)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL_A        = 8'h00;
	localparam logic [7:0] OFS_SYNC_STATUS      = 8'h01;
	localparam logic [7:0] OFS_IRQ_ENABLE       = 8'h02;
	localparam logic [7:0] OFS_IRQ_FLAGS        = 8'h03;
	localparam logic [7:0] OFS_WIDE_LATCH       = 8'h04;
	localparam logic [7:0] OFS_HALT_BEHAVIOUR   = 8'h05;
	localparam logic [7:0] OFS_CRYSTAL_TRIM     = 8'h06;
	localparam logic [7:0] OFS_SOURCE_SELECT    = 8'h07;
	localparam logic [7:0] OFS_COUNT_LO         = 8'h08;
	localparam logic [7:0] OFS_COUNT_HI         = 8'h09;
	localparam logic [7:0] OFS_TOP_LO           = 8'h0a;
	localparam logic [7:0] OFS_TOP_HI           = 8'h0b;
	localparam logic [7:0] OFS_MATCH_LO         = 8'h0c;
	localparam logic [7:0] OFS_MATCH_HI         = 8'h0d;
	localparam logic [7:0] OFS_TICK_CONTROL     = 8'h10;
	localparam logic [7:0] OFS_TICK_SYNC_STATUS = 8'h11;
	localparam logic [7:0] OFS_TICK_IRQ_ENABLE  = 8'h12;
	localparam logic [7:0] OFS_TICK_IRQ_FLAGS   = 8'h13;
	localparam logic [7:0] OFS_TICK_HALT        = 8'h15;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_COUNTER_ON    = 0;
	localparam int CTL_TRIM_ENABLE   = 2;
	localparam int CTL_PRESCALE_LSB  = 3;
	localparam int CTL_KEEP_STANDBY  = 7;
	localparam int FLG_WRAP          = 0;
	localparam int FLG_MATCH         = 1;
	localparam int TCTL_TICK_ON      = 0;
	localparam int TCTL_PERIOD_LSB   = 3;
	localparam int TAP_LOW_BIT       = 5;
	localparam int TAP_HIGH_BIT      = 12;

	// Index of each busy flag; the first four match the status bit order.
	localparam int SYN_CONTROL = 0;
	localparam int SYN_COUNT   = 1;
	localparam int SYN_TOP     = 2;
	localparam int SYN_MATCH   = 3;
	localparam int SYN_TICK    = 4;
	localparam int SYN_N       = 5;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [15:0] RST_COUNT     = 16'h0000;
	localparam logic [15:0] RST_TOP       = 16'hffff;
	localparam logic [15:0] RST_MATCH     = 16'h0000;
	localparam logic [14:0] RST_PRESCALE  = 15'h0000;
	localparam logic [3:0]  PERIOD_MAX    = 4'he;
	localparam logic [1:0]  SYNC_TICKS    = 2'h2;

endpackage

// >>> hw/rtc_tick_event_irq_logic.sv
// Real-time counter with periodic tick timer, events, flags and requests.
//
// Summary of operation
// [R1] Wrap and match events pulse one counter period.
// [R2] Tick taps divide counter clock 64 to 8192.
// [R3] Wrap flag raised when count wraps past top.
// [R4] Match flag raised when count equals match value.
// [R5] Tick flag raised each selected tick period.
// [R6] Flags set regardless of enable bits.
// [R7] Request held while enable and flag set.
// [R8] Counter and tick have separate flags, enables.
// [R9] Counter runs in idle; standby needs keep bit.
// [R10] Tick timer runs in every sleep mode.
// [R11] Four busy flags for control, count, top, match.
// [R12] Tick control has its own busy flag.
// [R13] Software waits for busy clear before writing.
// [R14] Writes apply after multi-cycle counter-clock delay.
// [R15] Counter stops when halted without run bit.
// [R16] Tick output forced low when halted, no run.
// [R17] High tick resumes with fresh edge and flag.
// [R18] Count resets to zero on wrap.
// [R19] Tick output toggles every half period.
// [R20] Writing one clears a flag; zero ignored.
// [R21] Prescaler change applies two counter ticks later.
// [R22] Busy clears once the value is applied.
// [R23] Counter and tick requests are separate lines.
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module rtc_tick_event_irq_logic (
	input  wire logic       I_CLK,
	input  wire logic       I_RESETN,
	input  wire logic [7:0] I_ADDR,
	input  wire logic [7:0] I_WR_DATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RD_DATA,
	input  wire logic       I_RTC_TICK,
	input  wire logic       I_STANDBY,
	input  wire logic       I_CPU_HALTED,
	output logic            O_WRAP_EVENT,
	output logic            O_MATCH_EVENT,
	output logic      [7:0] O_TICK_TAPS,
	output logic            O_TICK_OUT,
	output logic            O_CNT_IRQ,
	output logic            O_TICK_IRQ
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int      SYN_W = rtc_pkg::SYN_N;
	logic [7:0]         control_sh_ff;
	logic [7:0]         control_ff;
	logic [1:0]         irq_en_ff;
	logic [1:0]         irq_flags_ff;
	logic [7:0]         temp_ff;
	logic               halt_run_ff;
	logic [7:0]         trim_ff;
	logic [1:0]         source_choice_ff;
	logic [15:0]        count_sh_ff;
	logic [15:0]        top_sh_ff;
	logic [15:0]        match_sh_ff;
	logic [15:0]        count_ff;
	logic [15:0]        top_ff;
	logic [15:0]        match_ff;
	logic [7:0]         tick_control_sh_ff;
	logic [7:0]         tick_control_ff;
	logic               tick_irq_en_ff;
	logic               tick_flag_ff;
	logic               tick_halt_run_ff;
	logic [14:0]        prescale_ff;
	logic               wrap_event_ff;
	logic               match_event_ff;
	logic               tick_prev_ff;
	logic [7:0]         rd_data_ff;
	logic [SYN_W-1:0]   busy_ff;
	logic [1:0]         sync_cnt_ff [SYN_W];
	logic [SYN_W-1:0]   wr_hit;
	logic [SYN_W-1:0]   apply;
	logic               counter_run;
	logic               prescale_run;
	logic               step;
	logic               wrap_fire;
	logic               match_fire;
	logic               tick_level;
	logic               tick_rise;
	logic [1:0]         nxt_irq_flags;
	logic [7:0]         nxt_rd_data;

	function automatic logic wr_at(input logic [7:0] ofs);
		wr_at = I_WR && (I_ADDR == ofs);
	endfunction

	// True on the prescaler value just before the selected divider wraps.
	function automatic logic tap_step(input logic [14:0] psc, input logic [3:0] sel);
		logic [14:0] mask;
		mask = 15'((16'h0001 << sel) - 16'h0001);
		tap_step = ((psc & mask) == mask);
	endfunction

	// ----------------------------------------------------------------
	// Software-side register writes
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			control_sh_ff      <= rtc_pkg::RST_BYTE;
			irq_en_ff          <= 2'h0;
			halt_run_ff        <= 1'b0;
			trim_ff            <= rtc_pkg::RST_BYTE;
			source_choice_ff   <= 2'h0;
			tick_control_sh_ff <= rtc_pkg::RST_BYTE;
			tick_irq_en_ff     <= 1'b0;
			tick_halt_run_ff   <= 1'b0;
		end else begin
			if (wr_at(rtc_pkg::OFS_CONTROL_A)) control_sh_ff <= I_WR_DATA;
			if (wr_at(rtc_pkg::OFS_IRQ_ENABLE)) irq_en_ff <= I_WR_DATA[1:0];
			if (wr_at(rtc_pkg::OFS_HALT_BEHAVIOUR)) halt_run_ff <= I_WR_DATA[0];
			if (wr_at(rtc_pkg::OFS_CRYSTAL_TRIM)) trim_ff <= I_WR_DATA;
			if (wr_at(rtc_pkg::OFS_SOURCE_SELECT)) source_choice_ff <= I_WR_DATA[1:0];
			if (wr_at(rtc_pkg::OFS_TICK_CONTROL)) tick_control_sh_ff <= I_WR_DATA;
			if (wr_at(rtc_pkg::OFS_TICK_IRQ_ENABLE)) tick_irq_en_ff <= I_WR_DATA[0];
			if (wr_at(rtc_pkg::OFS_TICK_HALT)) tick_halt_run_ff <= I_WR_DATA[0];
		end
	end

	// Sixteen-bit registers commit on the high byte, using the latched low byte.
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			count_sh_ff <= rtc_pkg::RST_COUNT;
			top_sh_ff   <= rtc_pkg::RST_TOP;
			match_sh_ff <= rtc_pkg::RST_MATCH;
		end else begin
			if (wr_at(rtc_pkg::OFS_COUNT_HI)) count_sh_ff <= {I_WR_DATA, temp_ff};
			if (wr_at(rtc_pkg::OFS_TOP_HI)) top_sh_ff <= {I_WR_DATA, temp_ff};
			if (wr_at(rtc_pkg::OFS_MATCH_HI)) match_sh_ff <= {I_WR_DATA, temp_ff};
		end
	end

	// The latch is shared by all wide registers, so interleaved wide accesses
	// from two software contexts would corrupt each other.
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			temp_ff <= rtc_pkg::RST_BYTE;
		end else if (I_WR && (I_ADDR == rtc_pkg::OFS_WIDE_LATCH || I_ADDR == rtc_pkg::OFS_COUNT_LO ||
				I_ADDR == rtc_pkg::OFS_TOP_LO || I_ADDR == rtc_pkg::OFS_MATCH_LO)) begin
			temp_ff <= I_WR_DATA;
		end else if (I_RD && I_ADDR == rtc_pkg::OFS_COUNT_LO) begin
			temp_ff <= count_ff[15:8];
		end else if (I_RD && I_ADDR == rtc_pkg::OFS_TOP_LO) begin
			temp_ff <= top_ff[15:8];
		end else if (I_RD && I_ADDR == rtc_pkg::OFS_MATCH_LO) begin
			temp_ff <= match_ff[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Crossing into the counter clock: busy flags and apply strobes
	// ----------------------------------------------------------------
	always_comb begin
		wr_hit                       = '0;
		wr_hit[rtc_pkg::SYN_CONTROL] = wr_at(rtc_pkg::OFS_CONTROL_A);
		wr_hit[rtc_pkg::SYN_COUNT]   = wr_at(rtc_pkg::OFS_COUNT_HI);
		wr_hit[rtc_pkg::SYN_TOP]     = wr_at(rtc_pkg::OFS_TOP_HI);
		wr_hit[rtc_pkg::SYN_MATCH]   = wr_at(rtc_pkg::OFS_MATCH_HI);
		wr_hit[rtc_pkg::SYN_TICK]    = wr_at(rtc_pkg::OFS_TICK_CONTROL);
		for (int i = 0; i < SYN_W; i++) begin
			apply[i] = busy_ff[i] && I_RTC_TICK && !wr_hit[i] &&
				(sync_cnt_ff[i] == rtc_pkg::SYNC_TICKS - 2'h1); // see [R14] see [R21]
		end
	end

	// A write that lands while a crossing is pending restarts it, so the
	// last written value is the one applied.
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			busy_ff <= '0;
			for (int i = 0; i < SYN_W; i++)
				sync_cnt_ff[i] <= 2'h0;
		end else begin
			for (int i = 0; i < SYN_W; i++) begin
				if (wr_hit[i]) begin
					busy_ff[i]     <= 1'b1; // see [R11] see [R12]
					sync_cnt_ff[i] <= 2'h0;
				end else if (apply[i]) begin
					busy_ff[i]     <= 1'b0; // see [R22]
					sync_cnt_ff[i] <= 2'h0;
				end else if (busy_ff[i] && I_RTC_TICK) begin
					sync_cnt_ff[i] <= sync_cnt_ff[i] + 2'h1;
				end
			end
		end
	end

	// Active copies seen by the counter-clock logic.
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			control_ff      <= rtc_pkg::RST_BYTE;
			top_ff          <= rtc_pkg::RST_TOP;
			match_ff        <= rtc_pkg::RST_MATCH;
			tick_control_ff <= rtc_pkg::RST_BYTE;
		end else begin
			if (apply[rtc_pkg::SYN_CONTROL]) control_ff <= control_sh_ff; // see [R21]
			if (apply[rtc_pkg::SYN_TOP]) top_ff <= top_sh_ff;
			if (apply[rtc_pkg::SYN_MATCH]) match_ff <= match_sh_ff;
			if (apply[rtc_pkg::SYN_TICK]) tick_control_ff <= tick_control_sh_ff;
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and counter
	// ----------------------------------------------------------------
	assign counter_run = control_ff[rtc_pkg::CTL_COUNTER_ON] &&
		!(I_CPU_HALTED && !halt_run_ff) && // see [R15]
		!(I_STANDBY && !control_ff[rtc_pkg::CTL_KEEP_STANDBY]); // see [R9]
	// The tick timer ignores standby so the prescaler keeps running for it.
	assign prescale_run = counter_run || tick_control_ff[rtc_pkg::TCTL_TICK_ON]; // see [R10]
	assign step = I_RTC_TICK && counter_run && !apply[rtc_pkg::SYN_COUNT] &&
		tap_step(prescale_ff, control_ff[rtc_pkg::CTL_PRESCALE_LSB +: 4]);
	assign wrap_fire  = step && (count_ff == top_ff); // see [R3] see [R18]
	assign match_fire = step && (count_ff == match_ff); // see [R4]

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN)
			prescale_ff <= rtc_pkg::RST_PRESCALE;
		else if (!control_ff[rtc_pkg::CTL_COUNTER_ON] && !tick_control_ff[rtc_pkg::TCTL_TICK_ON])
			prescale_ff <= rtc_pkg::RST_PRESCALE;
		else if (I_RTC_TICK && prescale_run)
			prescale_ff <= prescale_ff + 15'h0001;
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) count_ff <= rtc_pkg::RST_COUNT;
		else if (apply[rtc_pkg::SYN_COUNT]) count_ff <= count_sh_ff;
		else if (wrap_fire) count_ff <= 16'h0000; // see [R18]
		else if (step) count_ff <= count_ff + 16'h0001;
	end

	// Events hold from one counter tick to the next.
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			wrap_event_ff  <= 1'b0;
			match_event_ff <= 1'b0;
		end else if (I_RTC_TICK) begin
			wrap_event_ff  <= wrap_fire; // see [R1]
			match_event_ff <= match_fire; // see [R1]
		end
	end

	// ----------------------------------------------------------------
	// Flags and requests
	// ----------------------------------------------------------------
	always_comb begin
		nxt_irq_flags = irq_flags_ff;
		if (wr_at(rtc_pkg::OFS_IRQ_FLAGS))
			nxt_irq_flags = irq_flags_ff & ~I_WR_DATA[1:0]; // see [R20]
		if (wrap_fire)
			nxt_irq_flags[rtc_pkg::FLG_WRAP] = 1'b1; // see [R6]
		if (match_fire)
			nxt_irq_flags[rtc_pkg::FLG_MATCH] = 1'b1; // see [R6]
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN)
			irq_flags_ff <= 2'h0;
		else
			irq_flags_ff <= nxt_irq_flags; // see [R8]
	end

	// ----------------------------------------------------------------
	// Tick timer
	// ----------------------------------------------------------------
	// Prescaler bit n has period 2^(n+1), a square wave toggling each half.
	assign tick_level = tick_control_ff[rtc_pkg::TCTL_TICK_ON] &&
		(tick_control_ff[rtc_pkg::TCTL_PERIOD_LSB +: 4] != 4'h0) &&
		(tick_control_ff[rtc_pkg::TCTL_PERIOD_LSB +: 4] <= rtc_pkg::PERIOD_MAX) &&
		prescale_ff[tick_control_ff[rtc_pkg::TCTL_PERIOD_LSB +: 4]] && // see [R19]
		!(I_CPU_HALTED && !tick_halt_run_ff); // see [R16]
	// Forcing the level low while halted makes the release produce the extra edge.
	assign tick_rise = tick_level && !tick_prev_ff; // see [R17]

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			tick_prev_ff <= 1'b0;
			tick_flag_ff <= 1'b0;
		end else begin
			tick_prev_ff <= tick_level;
			if (tick_rise) tick_flag_ff <= 1'b1; // see [R5] see [R6]
			else if (wr_at(rtc_pkg::OFS_TICK_IRQ_FLAGS) && I_WR_DATA[0]) tick_flag_ff <= 1'b0; // see [R20]
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rd_data = 8'h00;
		if (I_ADDR == rtc_pkg::OFS_CONTROL_A)
			nxt_rd_data = control_sh_ff;
		else if (I_ADDR == rtc_pkg::OFS_SYNC_STATUS)
			nxt_rd_data = {4'h0, busy_ff[3:0]}; // see [R11]
		else if (I_ADDR == rtc_pkg::OFS_IRQ_ENABLE)
			nxt_rd_data = {6'h00, irq_en_ff};
		else if (I_ADDR == rtc_pkg::OFS_IRQ_FLAGS)
			nxt_rd_data = {6'h00, irq_flags_ff};
		else if (I_ADDR == rtc_pkg::OFS_WIDE_LATCH)
			nxt_rd_data = temp_ff;
		else if (I_ADDR == rtc_pkg::OFS_HALT_BEHAVIOUR)
			nxt_rd_data = {7'h00, halt_run_ff};
		else if (I_ADDR == rtc_pkg::OFS_CRYSTAL_TRIM)
			nxt_rd_data = trim_ff;
		else if (I_ADDR == rtc_pkg::OFS_SOURCE_SELECT)
			nxt_rd_data = {6'h00, source_choice_ff};
		else if (I_ADDR == rtc_pkg::OFS_COUNT_LO)
			nxt_rd_data = count_ff[7:0];
		else if (I_ADDR == rtc_pkg::OFS_TOP_LO)
			nxt_rd_data = top_ff[7:0];
		else if (I_ADDR == rtc_pkg::OFS_MATCH_LO)
			nxt_rd_data = match_ff[7:0];
		else if (I_ADDR == rtc_pkg::OFS_COUNT_HI || I_ADDR == rtc_pkg::OFS_TOP_HI ||
				I_ADDR == rtc_pkg::OFS_MATCH_HI)
			nxt_rd_data = temp_ff;
		else if (I_ADDR == rtc_pkg::OFS_TICK_CONTROL)
			nxt_rd_data = tick_control_sh_ff;
		else if (I_ADDR == rtc_pkg::OFS_TICK_SYNC_STATUS)
			nxt_rd_data = {7'h00, busy_ff[rtc_pkg::SYN_TICK]}; // see [R12]
		else if (I_ADDR == rtc_pkg::OFS_TICK_IRQ_ENABLE)
			nxt_rd_data = {7'h00, tick_irq_en_ff};
		else if (I_ADDR == rtc_pkg::OFS_TICK_IRQ_FLAGS)
			nxt_rd_data = {7'h00, tick_flag_ff};
		else if (I_ADDR == rtc_pkg::OFS_TICK_HALT)
			nxt_rd_data = {7'h00, tick_halt_run_ff};
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RESETN)
			rd_data_ff <= 8'h00;
		else if (I_RD)
			rd_data_ff <= nxt_rd_data;
		else
			rd_data_ff <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign O_RD_DATA     = rd_data_ff;
	assign O_WRAP_EVENT  = wrap_event_ff;
	assign O_MATCH_EVENT = match_event_ff;
	assign O_TICK_TAPS   = prescale_ff[rtc_pkg::TAP_HIGH_BIT:rtc_pkg::TAP_LOW_BIT]; // see [R2]
	assign O_TICK_OUT    = tick_prev_ff;
	assign O_CNT_IRQ     = |(irq_flags_ff & irq_en_ff); // see [R7] see [R23]
	assign O_TICK_IRQ    = tick_flag_ff && tick_irq_en_ff; // see [R7] see [R23]

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_WRAP_EVENT_PULSE: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R1]
		wrap_fire |=> O_WRAP_EVENT && irq_flags_ff[rtc_pkg::FLG_WRAP])
		else $error("Wrap event or flag missing after wrap.");
	AST_MATCH_EVENT_PULSE: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R4]
		match_fire |=> O_MATCH_EVENT && irq_flags_ff[rtc_pkg::FLG_MATCH])
		else $error("Match event or flag missing after match.");
	AST_WRAP_TO_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R18]
		wrap_fire |=> (count_ff == 16'h0000))
		else $error("Count did not return to zero on wrap.");
	// Bus terms are written out so that the property sees sampled values, not the
	// values a function would read from the module after the edge.
	AST_FLAG_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R20]
		(I_WR && (I_ADDR == rtc_pkg::OFS_IRQ_FLAGS) && I_WR_DATA[rtc_pkg::FLG_WRAP] && !wrap_fire)
		|=> !irq_flags_ff[rtc_pkg::FLG_WRAP])
		else $error("Writing one did not clear the wrap flag.");
	AST_REQUEST_HELD: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R7]
		(O_TICK_IRQ && !(I_WR && (I_ADDR == rtc_pkg::OFS_TICK_IRQ_FLAGS || I_ADDR == rtc_pkg::OFS_TICK_IRQ_ENABLE)))
		|=> O_TICK_IRQ)
		else $error("Tick request dropped while flag and enable held.");
	AST_STANDBY_STOP: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R9]
		(I_STANDBY && !control_ff[rtc_pkg::CTL_KEEP_STANDBY] && !apply[rtc_pkg::SYN_COUNT])
		|=> $stable(count_ff))
		else $error("Counter moved in standby without keep bit.");
	AST_TICK_HALT_LOW: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R16]
		(I_CPU_HALTED && !tick_halt_run_ff) |=> !O_TICK_OUT)
		else $error("Tick output not low while halted.");
	AST_TICK_EDGE_FLAG: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R17]
		(tick_level && !O_TICK_OUT) |=> tick_flag_ff && O_TICK_OUT)
		else $error("Tick rising edge did not set the flag.");
	AST_TOP_APPLY: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R22]
		apply[rtc_pkg::SYN_TOP] |=> !busy_ff[rtc_pkg::SYN_TOP] && (top_ff == $past(top_sh_ff)))
		else $error("Top value applied without clearing busy.");
	AST_BUSY_ON_WRITE: assert property (@(posedge I_CLK) disable iff (!I_RESETN) // see [R11]
		wr_hit[rtc_pkg::SYN_MATCH] |=> busy_ff[rtc_pkg::SYN_MATCH] ##0 !apply[rtc_pkg::SYN_MATCH])
		else $error("Match busy not raised by write.");

endmodule

`default_nettype wire

// >>> bench/rtc_far_end_model.sv
// Far-side model of the event fabric that watches the wrap pulse and the lowest tick tap.
`timescale 1ns/10ps
`default_nettype none

module rtc_far_end_model #(
	parameter int TICK_DIV = 4
) (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic       i_wrap_event,
	input  wire logic [7:0] i_tick_taps,
	output logic      [7:0] o_n_wrap,
	output logic      [7:0] o_n_tap,
	output logic            o_width_bad
);
	logic [7:0] run_ff;
	logic       tap_ff;

	// A pulse that is too short or too long would be counted twice or missed by event users.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			run_ff      <= 8'h00;
			tap_ff      <= 1'b0;
			o_n_wrap    <= 8'h00;
			o_n_tap     <= 8'h00;
			o_width_bad <= 1'b0;
		end else begin
			run_ff <= i_wrap_event ? run_ff + 8'h01 : 8'h00;
			tap_ff <= i_tick_taps[0];
			if (!i_wrap_event && run_ff != 8'h00) begin
				o_n_wrap <= o_n_wrap + 8'h01;
				if (run_ff != 8'(TICK_DIV)) o_width_bad <= 1'b1;
			end
			if (i_tick_taps[0] && !tap_ff) o_n_tap <= o_n_tap + 8'h01;
		end
	end
endmodule

`default_nettype wire

// >>> bench/rtc_tick_event_irq_logic_tb.sv
// Self-checking testbench for the real-time counter and tick timer block.
`timescale 1ns/10ps
`default_nettype none

module rtc_tick_event_irq_logic_tb;
	logic       clk, resetn, wr, rd, tick, standby, halted, rd_seen, idle, seen_match;
	logic [7:0] addr, wdata, rdata, taps, n_wrap, n_tap, d;
	logic       wrap_ev, match_ev, tick_out, cnt_irq, tick_irq, width_bad;
	logic [1:0] tdiv;
	logic [8:0] exp_q[$];
	logic [7:0] ofs[13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h0e, 8'h14};
	int         fail_count, n_checks;

	rtc_tick_event_irq_logic u_dut (.I_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WR_DATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RD_DATA(rdata), .I_RTC_TICK(tick), .I_STANDBY(standby),
		.I_CPU_HALTED(halted), .O_WRAP_EVENT(wrap_ev), .O_MATCH_EVENT(match_ev), .O_TICK_TAPS(taps),
		.O_TICK_OUT(tick_out), .O_CNT_IRQ(cnt_irq), .O_TICK_IRQ(tick_irq));
	rtc_far_end_model #(.TICK_DIV(4)) u_far_end (.i_clk(clk), .i_resetn(resetn), .i_wrap_event(wrap_ev),
		.i_tick_taps(taps), .o_n_wrap(n_wrap), .o_n_tap(n_tap), .o_width_bad(width_bad));

	// ----------------------------------------------------------------
	// Clock, counter-clock enable and result watcher
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		tdiv       <= resetn ? tdiv + 2'h1 : 2'h0;
		tick       <= resetn && (tdiv == 2'h3);
		seen_match <= resetn && (seen_match || match_ev);
	end
	always @(posedge clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			if (exp_q[0][8]) cmp_rd(rdata, exp_q[0][7:0]);
			void'(exp_q.pop_front());
		end
		rd_seen <= rd;
	end

	task cmp_rd(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cmp_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] v, input logic c);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		exp_q.push_back({c, v});
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Software must not touch a crossing register until its busy bit drops.
	task wait_idle(input logic [7:0] a);
		idle = 1'b0;
		for (int i = 0; i < 60 && !idle; i++) begin
			rd_reg(a, 8'h00, 1'b0);
			@(negedge clk);
			idle = (rdata === 8'h00);
		end
		cmp_bit(idle, 1'b1);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask
	task close_out;
		$display("checks=%0d errors=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{resetn, wr, rd, standby, halted, addr, wdata} = '0;
		fail_count = 0;
		n_checks   = 0;
		d = 8'($urandom(32'hec4b6e18));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		foreach (ofs[i]) rd_reg(ofs[i], 8'h00, 1'b1);
		rd_reg(8'h0a, 8'hff, 1'b1);
		rd_reg(8'h0b, 8'hff, 1'b1);
		d = 8'($urandom);
		wr_reg(8'h06, d);
		rd_reg(8'h06, d, 1'b1);
		wr_reg(8'h0a, 8'h03);
		wr_reg(8'h0b, 8'h00);
		rd_reg(8'h01, 8'h04, 1'b1);
		wait_idle(8'h01);
		wr_reg(8'h0c, 8'h01);
		wr_reg(8'h0d, 8'h00);
		rd_reg(8'h01, 8'h08, 1'b1);
		wait_idle(8'h01);
		wr_reg(8'h00, 8'h01);
		rd_reg(8'h01, 8'h01, 1'b1);
		wait_idle(8'h01);
		wait_n(200);
		rd_reg(8'h03, 8'h03, 1'b1);
		@(negedge clk) cmp_bit(cnt_irq, 1'b0);
		wr_reg(8'h02, 8'h03);
		@(negedge clk) cmp_bit(cnt_irq, 1'b1);
		cmp_bit(n_wrap != 8'h00, 1'b1);
		cmp_bit(width_bad, 1'b0);
		cmp_bit(seen_match, 1'b1);
		wr_reg(8'h00, 8'h00);
		wait_idle(8'h01);
		wr_reg(8'h03, 8'h01);
		rd_reg(8'h03, 8'h02, 1'b1);
		@(negedge clk) cmp_bit(cnt_irq, 1'b1);
		wr_reg(8'h03, 8'h02);
		@(negedge clk) cmp_bit(cnt_irq, 1'b0);
		@(posedge clk);
		standby <= 1'b1;
		wr_reg(8'h00, 8'h01);
		wait_idle(8'h01);
		wait_n(100);
		rd_reg(8'h03, 8'h00, 1'b1);
		wr_reg(8'h00, 8'h81);
		wait_idle(8'h01);
		wait_n(100);
		rd_reg(8'h03, 8'h03, 1'b1);
		standby <= 1'b0;
		halted  <= 1'b1;
		wr_reg(8'h03, 8'h03);
		wait_n(100);
		rd_reg(8'h03, 8'h00, 1'b1);
		wr_reg(8'h05, 8'h01);
		wait_n(100);
		rd_reg(8'h03, 8'h03, 1'b1);
		wr_reg(8'h00, 8'h00);
		wait_idle(8'h01);
		wr_reg(8'h03, 8'h03);
		halted <= 1'b0;
		wr_reg(8'h12, 8'h01);
		wr_reg(8'h10, 8'h11);
		rd_reg(8'h11, 8'h01, 1'b1);
		wait_idle(8'h11);
		// Standby with the counter off: only the tick timer may set its flag now.
		wait_n(1);
		standby <= 1'b1;
		wr_reg(8'h13, 8'h01);
		wait_n(700);
		standby <= 1'b0;
		rd_reg(8'h13, 8'h01, 1'b1);
		@(negedge clk) cmp_bit(tick_irq, 1'b1);
		cmp_bit(cnt_irq, 1'b0);
		cmp_bit(n_tap != 8'h00, 1'b1);
		@(posedge clk);
		halted <= 1'b1;
		wait_n(4);
		repeat (40) @(negedge clk) cmp_bit(tick_out, 1'b0);
		close_out();
	end

	initial begin
		#(30000 * 100);
		fail_count++;
		close_out();
	end
endmodule

`default_nettype wire
